// ### hlost_ext_src.sv
/* Far-side source of the external trigger/reset signal.
 Assumes the bench sets want; the pin follows 3 ns after a clock edge, off the sampling edge. */
`timescale 1ns/1ps
`default_nettype none
module hlost_ext_src (
   input wire logic clock,
   input wire logic want,
   output logic external_trigger_reset
);
   initial external_trigger_reset = 1'b0;
   always @(posedge clock) begin
      external_trigger_reset <= #3 want;
   end
endmodule : hlost_ext_src
`default_nettype wire

// ### hlost_pkg.sv
/*
 Package for the hardware-limit one-shot timer: mode codes, widths, timing counts
 and the carrier structs.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package hlost_pkg;
   // ----------------------------------------
   // Widths and reset values
   // ----------------------------------------
   localparam int unsigned HLOST_W = 8;
   localparam int unsigned HLOST_MODE_W = 5;
   localparam logic [7:0] HLOST_PERIOD_RST = 8'hff;
   localparam logic [7:0] HLOST_COUNT_RST = 8'h00;
   // Restart delay after a reset edge, in timer clocks
   localparam logic [1:0] HLOST_RESUME_CLKS = 2'h2;

   // ----------------------------------------
   // Mode codes
   // ----------------------------------------
   localparam logic [4:0] HLOST_MODE_EDGE_RISE = 5'h0c;
   localparam logic [4:0] HLOST_MODE_EDGE_FALL = 5'h0d;
   localparam logic [4:0] HLOST_MODE_LVLE_LOW = 5'h0e;
   localparam logic [4:0] HLOST_MODE_LVLE_HIGH = 5'h0f;
   localparam logic [4:0] HLOST_MODE_MONO_RISE = 5'h11;
   localparam logic [4:0] HLOST_MODE_MONO_FALL = 5'h12;
   localparam logic [4:0] HLOST_MODE_MONO_BOTH = 5'h13;
   localparam logic [4:0] HLOST_MODE_LVL_LOW = 5'h16;
   localparam logic [4:0] HLOST_MODE_LVL_HIGH = 5'h17;

   typedef enum logic [1:0] {
      HLOST_IDLE,
      HLOST_RUN,
      HLOST_HOLD,
      HLOST_DONE
   } hlost_state_t;

   // Status outputs travel together
   typedef struct packed {
      logic [7:0] count_value;
      logic run_bit;
      logic pwm_out;
      logic period_match;
   } hlost_status_t;
endpackage : hlost_pkg

// ### hlost_sync.sv
/*
 Two-flop synchroniser with a third stage for edge detection.
 Assumes an asynchronous active-low reset already released in the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module hlost_sync (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic async_in,
   output logic level,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } hlost_sync_t;
   hlost_sync_t r_q;
   hlost_sync_t r_d;

   // ----------------------------------------
   // Sample and compare
   // ----------------------------------------
   always_comb begin
      r_d.s1 = async_in;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign level = r_q.s2;
   assign rise = r_q.s2 & ~r_q.s3; // RULE17
   assign fall = ~r_q.s2 & r_q.s3; // RULE17
endmodule : hlost_sync
`default_nettype wire

// ### hlost_timer.sv
/*
 Mode control for an 8-bit period timer in its hardware-limit modes, with PWM drive.
 Assumes run-bit set/clear requests arrive from software on any cycle and the
 external trigger/reset signal is unrelated to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: In edge hardware-limit modes the first selected edge after run starts the count and later edges reset it.
// RULE2: After a later reset edge the count resumes by itself two timer clocks afterwards.
// RULE3: In edge hardware-limit mode a period match resets the count and clears the run bit.
// RULE4: In edge hardware-limit mode edges are ignored until the run bit is set.
// RULE5: In edge hardware-limit mode start and reset edges raise the PWM drive, the width match drops it.
// RULE6: In level-reset edge mode the reset level holds the count and the edge to active level starts it.
// RULE7: In level-reset edge mode a period match clears run and a fresh edge is needed after run returns.
// RULE8: In level-reset edge mode PWM rises on the start edge, falls on width match, not at period match.
// RULE9: In monostable modes the selected edge starts the count; at the period value it clears and stays stopped.
// RULE10: In monostable modes PWM rises on the start edge only and later edges leave it alone.
// RULE11: In level hardware-limit modes the count runs when run is set and the signal is off reset level.
// RULE12: In level hardware-limit mode a period match resets the count and clears the run bit.
// RULE13: In level hardware-limit mode PWM rises on whichever event starts the count.
// RULE14: Run-bit set and clear requests are accepted on any cycle regardless of timer phase.
// RULE15: Whenever the count equals the period value the next clock clears the count.
// RULE16: While the run bit is zero all counters and state are held in reset. The code clears them on the clock after run_bit falls.
// RULE17: The external signal is synchronised and edges are found by comparing consecutive samples.
module hlost_timer
   import hlost_pkg::*;
#(
   parameter int unsigned W = HLOST_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic run_set,
   input wire logic run_clear,
   input wire logic [4:0] mode,
   input wire logic [W-1:0] period_value,
   input wire logic [W-1:0] pulse_width_value,
   input wire logic external_trigger_reset,
   output logic [W-1:0] count_value,
   output logic run_bit,
   output logic pwm_out,
   output logic period_match
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------
   // External signal
   // ----------------------------------------
   logic ers_level;
   logic ers_rise;
   logic ers_fall;

   hlost_sync u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(external_trigger_reset),
      .level(ers_level),
      .rise(ers_rise),
      .fall(ers_fall)
   );

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   function automatic logic is_mode(input logic [4:0] m, input logic [4:0] a,
         input logic [4:0] b);
      is_mode = (m == a) || (m == b);
   endfunction : is_mode

   logic m_edge;
   logic m_lvle;
   logic m_mono;
   logic m_lvl;
   logic sel_edge;
   logic at_reset_lvl;

   always_comb begin
      m_edge = is_mode(mode, HLOST_MODE_EDGE_RISE, HLOST_MODE_EDGE_FALL);
      m_lvle = is_mode(mode, HLOST_MODE_LVLE_LOW, HLOST_MODE_LVLE_HIGH);
      m_mono = is_mode(mode, HLOST_MODE_MONO_RISE, HLOST_MODE_MONO_FALL)
            || (mode == HLOST_MODE_MONO_BOTH);
      m_lvl = is_mode(mode, HLOST_MODE_LVL_LOW, HLOST_MODE_LVL_HIGH);
      // Low bit picks falling edge (rising edge in monostable modes, both edges in HLOST_MODE_MONO_BOTH) / high reset level
      at_reset_lvl = mode[0] ? ers_level : ~ers_level;
      sel_edge = 1'b0;
      if (m_edge) begin
         sel_edge = mode[0] ? ers_fall : ers_rise;
      end else if (m_lvle) begin
         sel_edge = mode[0] ? ers_fall : ers_rise;
      end else if (m_mono) begin
         sel_edge = (mode == HLOST_MODE_MONO_BOTH) ? (ers_rise | ers_fall)
               : (mode[0] ? ers_rise : ers_fall);
      end
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      hlost_state_t st;
      logic [W-1:0] cnt;
      logic run;
      logic pwm;
      logic match;
      logic [1:0] wait_cnt;
   } hlost_core_t;

   hlost_core_t r_q;
   hlost_core_t r_d;
   logic at_period;
   logic at_width;

   always_comb begin
      r_d = r_q;
      r_d.match = 1'b0;
      at_period = (r_q.cnt == period_value);
      at_width = (r_q.cnt == pulse_width_value);
      // Set wins over clear, both taken on any cycle
      if (run_clear) begin
         r_d.run = 1'b0; // RULE14
      end
      if (run_set) begin
         r_d.run = 1'b1; // RULE14
      end
      if (!r_q.run) begin
         r_d.st = HLOST_IDLE; // RULE16
         r_d.cnt = HLOST_COUNT_RST; // RULE16
         r_d.pwm = 1'b0;
         r_d.wait_cnt = 2'h0;
      end else begin
         if (r_q.st == HLOST_RUN && at_width) begin
            r_d.pwm = 1'b0; // RULE5 RULE8
         end
         unique case (r_q.st)
            HLOST_IDLE: begin
               r_d.cnt = HLOST_COUNT_RST;
               if ((m_edge || m_lvle || m_mono) && sel_edge
                     && !(m_lvle && at_reset_lvl)) begin
                  r_d.st = HLOST_RUN; // RULE1 RULE4 RULE6 RULE9
                  r_d.pwm = 1'b1; // RULE5 RULE8 RULE10
               end else if (m_lvl && !at_reset_lvl) begin
                  r_d.st = HLOST_RUN; // RULE11
                  r_d.pwm = 1'b1; // RULE13
               end
            end
            HLOST_RUN: begin
               r_d.cnt = W'(r_q.cnt + 1'b1);
               if (at_period) begin
                  r_d.cnt = HLOST_COUNT_RST; // RULE15
                  r_d.match = 1'b1;
                  if (m_mono) begin
                     // Count clears as usual, then stays stopped with run kept
                     r_d.st = HLOST_DONE; // RULE9
                  end else begin
                     r_d.run = run_set; // RULE3 RULE7 RULE12
                     r_d.st = HLOST_IDLE;
                  end
               end
               if (m_edge && sel_edge) begin
                  r_d.cnt = HLOST_COUNT_RST; // RULE1
                  r_d.pwm = 1'b1; // RULE5
                  r_d.st = HLOST_HOLD;
                  r_d.wait_cnt = HLOST_RESUME_CLKS - 2'h1;
               end else if ((m_lvle || m_lvl) && at_reset_lvl) begin
                  r_d.cnt = HLOST_COUNT_RST; // RULE6 RULE11
                  r_d.pwm = 1'b0;
                  r_d.st = m_lvl ? HLOST_IDLE : HLOST_HOLD;
               end
            end
            HLOST_HOLD: begin
               r_d.cnt = HLOST_COUNT_RST;
               if (m_edge) begin
                  if (sel_edge) begin
                     r_d.wait_cnt = HLOST_RESUME_CLKS - 2'h1; // RULE2
                  end else if (r_q.wait_cnt == 2'h0) begin
                     r_d.st = HLOST_RUN; // RULE2
                  end else begin
                     r_d.wait_cnt = r_q.wait_cnt - 2'h1;
                  end
               end else if (sel_edge && !at_reset_lvl) begin
                  r_d.st = HLOST_RUN; // RULE6
                  r_d.pwm = 1'b1; // RULE8
               end
            end
            HLOST_DONE: begin
               // Count clears after the match, then waits for software
               r_d.cnt = HLOST_COUNT_RST; // RULE15
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= '{st: HLOST_IDLE, cnt: HLOST_COUNT_RST, run: 1'b0, pwm: 1'b0,
               match: 1'b0, wait_cnt: 2'h0};
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign count_value = r_q.cnt;
   assign run_bit = r_q.run;
   assign pwm_out = r_q.pwm;
   assign period_match = r_q.match;
endmodule : hlost_timer
`default_nettype wire

// ### hlost_timer_bench.sv
/* Bench for hlost_timer: every mode, reset edges, restart conditions.
 Assumes the package, source model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module hlost_timer_bench;
   import hlost_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic run_set = 1'b0;
   logic run_clear = 1'b0;
   logic want = 1'b0;
   logic external_trigger_reset;
   logic [4:0] mode = HLOST_MODE_EDGE_RISE;
   logic [7:0] period_value = 8'h06;
   logic [7:0] pulse_width_value = 8'h03;
   logic [7:0] count_value;
   logic run_bit, pwm_out, period_match;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   hlost_timer u_hlost_timer (
      .clock(clock),
      .nrst(nrst),
      .run_set(run_set),
      .run_clear(run_clear),
      .mode(mode),
      .period_value(period_value),
      .pulse_width_value(pulse_width_value),
      .external_trigger_reset(external_trigger_reset),
      .count_value(count_value),
      .run_bit(run_bit),
      .pwm_out(pwm_out),
      .period_match(period_match)
   );
   hlost_ext_src u_hlost_ext_src (
      .clock(clock),
      .want(want),
      .external_trigger_reset(external_trigger_reset)
   );
   initial forever #4 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick
   task automatic till(input logic [7:0] v);
      for (int i = 0; i < 40 && count_value !== v; i++) tick(1);
      chk("count reached", count_value, v);
   endtask : till
   task automatic pulse(input logic clr);
      if (clr) run_clear = 1'b1;
      else run_set = 1'b1;
      tick(1);
      run_set = 1'b0;
      run_clear = 1'b0;
      tick(1);
   endtask : pulse
   task automatic t_modes();
      logic [4:0] codes [9] = '{5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h16, 5'h17};
      logic [8:0] lvl = 9'h0d5;
      for (int i = 0; i < 9; i++) begin
         mode = codes[i];
         want = !lvl[i];
         tick(6);
         pulse(1'b0);
         tick(6);
         chk("count before start", count_value, 8'h00);
         chk("run bit", {7'h00, run_bit}, 8'h01);
         want = lvl[i];
         till(8'h02);
         chk("pwm at start", {7'h00, pwm_out}, 8'h01);
         if (i inside {4, 5, 6}) want = !want;
         till(8'h05);
         chk("pwm after width", {7'h00, pwm_out}, 8'h00);
         tick(2);
         chk("count cleared at match", count_value, 8'h00);
         chk("match pulse", {7'h00, period_match}, 8'h01);
         tick(2);
         chk("pwm after period", {7'h00, pwm_out}, 8'h00);
         if (i inside {4, 5, 6}) begin
            chk("mono stopped", count_value, 8'h00);
            chk("mono run kept", {7'h00, run_bit}, 8'h01);
         end else begin
            chk("run after match", {7'h00, run_bit}, 8'h00);
         end
         pulse(1'b1);
         chk("count off", count_value, 8'h00);
      end
      $display("modes done");
   endtask : t_modes
   task automatic t_restart();
      period_value = 8'h0c;
      mode = HLOST_MODE_EDGE_RISE;
      want = 1'b0;
      tick(6);
      pulse(1'b0);
      want = 1'b1;
      till(8'h04);
      want = 1'b0;
      tick(2);
      want = 1'b1;
      till(8'h00);
      till(8'h01);
      chk("pwm after reset edge", {7'h00, pwm_out}, 8'h01);
      tick(14);
      chk("run after match", {7'h00, run_bit}, 8'h00);
      mode = HLOST_MODE_LVLE_LOW;
      pulse(1'b0);
      tick(8);
      chk("no start without edge", count_value, 8'h00);
      pulse(1'b1);
      mode = HLOST_MODE_LVL_LOW;
      pulse(1'b0);
      till(8'h02);
      chk("pwm on run start", {7'h00, pwm_out}, 8'h01);
      $display("restart done");
   endtask : t_restart
   initial begin
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      tick(3);
      t_modes();
      t_restart();
      conclude();
   end
endmodule : hlost_timer_bench
`default_nettype wire

// ### hlost_timer_chk.sv
/* Port checker for hlost_timer.
 Assumes it is bound to hlost_timer and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module hlost_timer_chk
   import hlost_pkg::*;
#(
   parameter int unsigned W = HLOST_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic run_set,
   input wire logic run_clear,
   input wire logic [4:0] mode,
   input wire logic [W-1:0] period_value,
   input wire logic [W-1:0] pulse_width_value,
   input wire logic [W-1:0] count_value,
   input wire logic run_bit,
   input wire logic pwm_out,
   input wire logic period_match
);
   wire logic mono = mode inside {HLOST_MODE_MONO_RISE, HLOST_MODE_MONO_FALL,
      HLOST_MODE_MONO_BOTH};
   wire logic edg = mode inside {HLOST_MODE_EDGE_RISE, HLOST_MODE_EDGE_FALL};
   wire logic hit = run_bit && count_value == period_value;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   a_set_takes: assert property (run_set |=> run_bit)
      else $error("run bit not set");
   a_clear_drops: assert property (run_clear && !run_set |=> !run_bit)
      else $error("run bit not cleared");
   a_off_held: assert property ((!run_bit)[*2] |-> count_value == '0 && !pwm_out)
      else $error("timer active while off");
   a_match_clears: assert property (hit && !mono && !run_set
      |=> count_value == '0 && !run_bit)
      else $error("period match did not clear");
   a_mono_holds: assert property (hit && mono && !run_clear
      |=> count_value == '0 && run_bit ##1 count_value == '0)
      else $error("monostable count moved");
   a_resume_two: assert property (edg && run_bit && count_value != '0
      ##1 run_bit && count_value == '0 |-> ##[2:3] count_value == W'(1))
      else $error("count did not resume");
   a_width_drop: assert property (run_bit && pwm_out && count_value != '0
      && count_value == pulse_width_value |=> !pwm_out)
      else $error("pwm not dropped at width");
   a_pwm_start: assert property ($rose(pwm_out)
      |-> run_bit && count_value == '0)
      else $error("pwm rose off start");
   a_match_flag: assert property (period_match |-> $past(hit))
      else $error("match flag without match");
endmodule : hlost_timer_chk
bind hlost_timer hlost_timer_chk #(.W(W)) u_hlost_timer_chk (
   .clock(clock),
   .nrst(nrst),
   .run_set(run_set),
   .run_clear(run_clear),
   .mode(mode),
   .period_value(period_value),
   .pulse_width_value(pulse_width_value),
   .count_value(count_value),
   .run_bit(run_bit),
   .pwm_out(pwm_out),
   .period_match(period_match)
);
`default_nettype wire
